// file: inc/ccc_defines.svh
/*
  Offsets, field positions, reset values and clock counts of the
  chopper and smart current block.
  Assumes a 100 MHz system clock; all counts are in its cycles.
*/
// Operation
// - Hysteresis low codes 0..15 mean -3..12
// - Off-time mode: same field is sine offset
// - Hysteresis start codes add 1..8
// - Hysteresis decrements once every 16 clocks
// - Fast decay 32 clocks per count, zero skips
// - Slow decay lasts 24 plus 32 times value
// - Off-time zero disables driver, bridges off
// - Filter bit: update every four full steps
// - Signed stall threshold, higher means less sensitive
// - Minimum current half or quarter of run
// - Decrease after 32, 8, 2, 1 values
// - Reduce at or above (low+hyst+1)*32
// - Increase by 1, 2, 4, 8 steps
// - Increase below low threshold times 32
// - Low threshold zero disables current control
// - Mode bit selects hysteresis or off-time
// - Chopper bit 11 is fast decay top bit
`ifndef CCC_DEFINES_SVH
`define CCC_DEFINES_SVH

// Register offsets
`define CCC_OFS_CTRL 7'h10
`define CCC_OFS_CHOP 7'h6c
`define CCC_OFS_COOL 7'h6d
`define CCC_OFS_STAT 7'h6f

// Chopper register fields
`define CCC_SLOW_TIME 3:0
`define CCC_HYST_START 6:4
`define CCC_HYST_LOW 10:7
`define CCC_FAST_TOP 11
`define CCC_CHM 14
`define CCC_BLANK 16:15
`define CCC_CHOP_MASK 32'h0001_cfff
`define CCC_CHOP_RST 32'h0000_0000

// Smart current register fields
`define CCC_SEMIN 3:0
`define CCC_SEUP 6:5
`define CCC_SEMAX 11:8
`define CCC_SEDN 14:13
`define CCC_SEIMIN 15
`define CCC_SGT 22:16
`define CCC_SFILT 24
`define CCC_COOL_MASK 32'h017f_ef6f
`define CCC_COOL_RST 32'h0000_0000

// Control register: run current
`define CCC_RUN_CUR 12:8
`define CCC_CTRL_MASK 32'h0000_1f00
`define CCC_CTRL_RST 32'h0000_1f00

// Status register fields
`define CCC_ST_RES 9:0
`define CCC_ST_CS 20:16
`define CCC_ST_STALL 24
`define CCC_ST_PH 29:28
`define CCC_ST_EN 31

// Timing in clock cycles; load step, low bias, full steps per update
`define CCC_SLOW_BASE 24
`define CCC_SLOW_STEP 32
`define CCC_FAST_STEP 32
`define CCC_HYST_DIV 16
`define CCC_LOAD_STEP 32
`define CCC_LOW_BIAS 3
`define CCC_FS_PER_UPD 4

`endif

// file: inc/ccc_pkg.sv
/*
  Types shared by the chopper and smart current block.
  Assumes ccc_defines.svh for all numeric constants.
*/
package ccc_pkg;

  // Chopper phase
  typedef enum logic [1:0] {PH_OFF, PH_ON, PH_FAST, PH_SLOW} ccc_phase_t;

  // Register port request
  typedef struct packed {
    logic [6:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ccc_req_t;

  // Raw load measurement from the step logic
  typedef struct packed {
    logic valid;
    logic [9:0] value;
  } ccc_load_t;

  // Whole state of the top module
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] chop;
    logic [31:0] cool;
    logic [31:0] rdata;
    ccc_phase_t phase;
    logic [8:0] tmr;
    logic signed [5:0] hyst;
    logic [3:0] hdiv;
    logic [1:0] fs_cnt;
    logic fs_ready;
    logic [9:0] result;
    logic stall;
    logic [4:0] cs;
    logic [5:0] dn_cnt;
  } ccc_state_t;

endpackage : ccc_pkg

// file: src/ccc_sync.sv
/*
  Two-stage synchroniser for pin inputs.
  Assumes the inputs are asynchronous to sys_clk_in.
*/
`timescale 1ns/10ps
`default_nettype none

module ccc_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ccc_sync_t;

  ccc_sync_t st;
  ccc_sync_t next_st;

  if (WIDTH < 1) begin : g_chk
    $error("ccc_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second
  always_comb begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;

endmodule : ccc_sync
`default_nettype wire

// file: src/ccc_top.sv
/*
  Chopper phase timing and load-adaptive current scale.
  Assumes a register port on sys_clk_in, comparator pins from the
  analog side, and load values and full-step pulses from logic on
  the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ccc_defines.svh"

module ccc_top (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire ccc_pkg::ccc_req_t bus_in,
  output logic [31:0] rdata_out,
  input wire logic peak_reached_in,
  input wire logic valley_reached_in,
  input wire ccc_pkg::ccc_load_t load_in,
  input wire logic full_step_in,
  output ccc_pkg::ccc_phase_t phase_out,
  output logic drv_enable_out,
  output logic signed [5:0] hyst_offset_out,
  output logic signed [5:0] sine_offset_out,
  output logic stall_out,
  output logic [4:0] cs_out,
  output logic [9:0] load_result_out
);
  ccc_pkg::ccc_state_t st;
  ccc_pkg::ccc_state_t next_st;
  logic [1:0] pins_s;
  logic pk_s;
  logic vl_s;

  // Comparators are analog pins and need two flops
  ccc_sync #(.WIDTH(2)) i_ccc_sync (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .async_in({peak_reached_in, valley_reached_in}),
    .sync_out(pins_s)
  );
  assign pk_s = pins_s[1];
  assign vl_s = pins_s[0];

  // Field views
  logic [3:0] off_code;
  logic [3:0] low_code;
  logic [2:0] start_code;
  logic chm;
  logic [3:0] fast_code;
  logic [3:0] semin;
  logic [3:0] semax;
  logic [4:0] run_cur;
  logic [4:0] cs_min;
  logic signed [5:0] low_v;
  logic signed [5:0] hstart_v;
  logic [9:0] lo_thr;
  logic [9:0] hi_thr;
  logic [5:0] dn_lim;
  logic signed [11:0] res_sum;
  logic [9:0] res;
  logic acc;
  logic reload;

  always_comb begin
    off_code = st.chop[`CCC_SLOW_TIME];
    low_code = st.chop[`CCC_HYST_LOW];
    start_code = st.chop[`CCC_HYST_START];
    chm = st.chop[`CCC_CHM];
    fast_code = {st.chop[`CCC_FAST_TOP], start_code};
    semin = st.cool[`CCC_SEMIN];
    semax = st.cool[`CCC_SEMAX];
    run_cur = st.ctrl[`CCC_RUN_CUR];
  end

  // Hysteresis end and start in 1/512 units of current
  assign low_v = $signed({2'h0, low_code}) - 6'(`CCC_LOW_BIAS);
  assign hstart_v = low_v + $signed({3'h0, start_code}) + 6'sd1;
  // Sine offset is only meaningful in off-time mode
  assign sine_offset_out = chm ? low_v : 6'sh00;

  // Minimum current: half or quarter of run current
  assign cs_min = st.cool[`CCC_SEIMIN] ? (run_cur >> 2) : (run_cur >> 1);
  assign lo_thr = 10'(semin * `CCC_LOAD_STEP);
  assign hi_thr = 10'((semin + semax + 1) * `CCC_LOAD_STEP);

  // Down-step divider per code
  always_comb begin
    unique case (st.cool[`CCC_SEDN])
      2'b00: dn_lim = 6'd32;
      2'b01: dn_lim = 6'd8;
      2'b10: dn_lim = 6'd2;
      2'b11: dn_lim = 6'd1;
    endcase
  end

  // Threshold shifts the result; saturated so it never wraps
  assign res_sum = $signed({2'h0, load_in.value})
    + $signed({st.cool[22], st.cool[`CCC_SGT], 4'h0});
  assign res = res_sum < 0 ? 10'h000 :
    (res_sum > 12'sd1023 ? 10'h3ff : res_sum[9:0]);

  // Filtered mode only accepts one value per four full steps
  assign acc = load_in.valid && (!st.cool[`CCC_SFILT] || st.fs_ready);

  // Next state
  always_comb begin
    next_st = st;
    next_st.rdata = 32'h0000_0000;
    // Register writes keep only implemented bits
    if (bus_in.wr) begin
      case (bus_in.addr)
        `CCC_OFS_CTRL: next_st.ctrl = bus_in.wdata & `CCC_CTRL_MASK;
        `CCC_OFS_CHOP: next_st.chop = bus_in.wdata & `CCC_CHOP_MASK;
        `CCC_OFS_COOL: next_st.cool = bus_in.wdata & `CCC_COOL_MASK;
        default: ;
      endcase
    end
    // Reads answer next cycle; unmapped reads give zero
    if (bus_in.rd) begin
      case (bus_in.addr)
        `CCC_OFS_CTRL: next_st.rdata = st.ctrl;
        `CCC_OFS_CHOP: next_st.rdata = st.chop;
        `CCC_OFS_COOL: next_st.rdata = st.cool;
        `CCC_OFS_STAT: begin
          next_st.rdata[`CCC_ST_RES] = st.result;
          next_st.rdata[`CCC_ST_CS] = st.cs;
          next_st.rdata[`CCC_ST_STALL] = st.stall;
          next_st.rdata[`CCC_ST_PH] = st.phase;
          next_st.rdata[`CCC_ST_EN] = st.phase != ccc_pkg::PH_OFF;
        end
        default: ;
      endcase
    end

    // Chopper phases; off-time zero forces the bridges off
    if (off_code == 4'h0) begin
      next_st.phase = ccc_pkg::PH_OFF;
      next_st.tmr = 9'h000;
    end else begin
      unique case (st.phase)
        ccc_pkg::PH_OFF: next_st.phase = ccc_pkg::PH_ON;
        ccc_pkg::PH_ON: begin
          if (pk_s) begin
            if (chm && fast_code == 4'h0) begin
              // Zero fast time means slow decay only
              next_st.phase = ccc_pkg::PH_SLOW;
              next_st.tmr = 9'(`CCC_SLOW_BASE + `CCC_SLOW_STEP * off_code - 1);
            end else begin
              next_st.phase = ccc_pkg::PH_FAST;
              next_st.tmr = chm ? 9'(`CCC_FAST_STEP * fast_code - 1) : 9'h000;
            end
          end
        end
        ccc_pkg::PH_FAST: begin
          // Off-time mode ends on timer or on the valley comparator
          if (vl_s || (chm && st.tmr == 9'h000)) begin
            next_st.phase = ccc_pkg::PH_SLOW;
            next_st.tmr = 9'(`CCC_SLOW_BASE + `CCC_SLOW_STEP * off_code - 1);
          end else if (chm) begin
            next_st.tmr = st.tmr - 9'h001;
          end
        end
        ccc_pkg::PH_SLOW: begin
          if (st.tmr == 9'h000) begin
            next_st.phase = ccc_pkg::PH_ON;
          end else begin
            next_st.tmr = st.tmr - 9'h001;
          end
        end
      endcase
    end

    // Entry to on phase, decided above; kept inside this process to avoid a loop
    reload = (st.phase != ccc_pkg::PH_ON) && (next_st.phase == ccc_pkg::PH_ON);
    // Hysteresis restarts each cycle and steps down every 16 clocks
    if (reload) begin
      next_st.hyst = hstart_v;
      next_st.hdiv = 4'h0;
    end else begin
      next_st.hdiv = st.hdiv + 4'h1;
      if (st.hdiv == 4'(`CCC_HYST_DIV - 1) && st.hyst > low_v) begin
        next_st.hyst = st.hyst - 6'sd1;
      end
    end

    // Full-step gate: clear on use first so a new set wins
    if (acc && st.cool[`CCC_SFILT]) begin
      next_st.fs_ready = 1'b0;
    end
    if (full_step_in) begin
      next_st.fs_cnt = st.fs_cnt + 2'h1;
      if (st.fs_cnt == 2'(`CCC_FS_PER_UPD - 1)) begin
        next_st.fs_ready = 1'b1;
      end
    end
    if (acc) begin
      next_st.result = res;
      next_st.stall = res == 10'h000;
    end

    // Adaptive current scale
    if (semin == 4'h0) begin
      next_st.cs = run_cur;
      next_st.dn_cnt = 6'h00;
    end else if (acc) begin
      if (res < lo_thr) begin
        next_st.cs = 5'(6'(st.cs) + (6'h01 << st.cool[`CCC_SEUP]) > 6'(run_cur) ?
          run_cur : st.cs + (5'h01 << st.cool[`CCC_SEUP]));
        next_st.dn_cnt = 6'h00;
      end else if (res >= hi_thr) begin
        if (st.dn_cnt + 6'h01 >= dn_lim) begin
          next_st.cs = st.cs - 5'h01;
          next_st.dn_cnt = 6'h00;
        end else begin
          next_st.dn_cnt = st.dn_cnt + 6'h01;
        end
      end
    end
    // Clamp after every change, also after register writes
    if (semin != 4'h0) begin
      if (next_st.cs > run_cur || st.cs == 5'h00 && run_cur == 5'h00) begin
        next_st.cs = run_cur;
      end else if (next_st.cs < cs_min || st.cs < cs_min) begin
        next_st.cs = cs_min;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st <= '0;
      st.ctrl <= `CCC_CTRL_RST;
      st.chop <= `CCC_CHOP_RST;
      st.cool <= `CCC_COOL_RST;
      st.cs <= 5'h1f;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign rdata_out = st.rdata;
  assign phase_out = st.phase;
  assign drv_enable_out = st.phase != ccc_pkg::PH_OFF;
  assign hyst_offset_out = chm ? 6'sh00 : st.hyst;
  assign stall_out = st.stall;
  assign cs_out = st.cs;
  assign load_result_out = st.result;

  // Phase length counters read only by the checks below
  logic [9:0] slow_cnt;
  logic [9:0] fast_cnt;
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      slow_cnt <= 10'h000;
      fast_cnt <= 10'h000;
    end else begin
      slow_cnt <= st.phase == ccc_pkg::PH_SLOW ? slow_cnt + 10'h001 : 10'h000;
      fast_cnt <= st.phase == ccc_pkg::PH_FAST ? fast_cnt + 10'h001 : 10'h000;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  property p_drv_off;
    off_code == 4'h0 |=> phase_out == ccc_pkg::PH_OFF && !drv_enable_out;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver not off");

  property p_slow_len;
    st.phase == ccc_pkg::PH_SLOW && next_st.phase == ccc_pkg::PH_ON && !bus_in.wr
      |-> 32'(slow_cnt) == `CCC_SLOW_BASE + `CCC_SLOW_STEP * off_code - 1;
  endproperty
  a_slow_len: assert property (p_slow_len) else $error("slow decay length");

  property p_fast_len;
    st.phase == ccc_pkg::PH_FAST && chm && !vl_s && next_st.phase == ccc_pkg::PH_SLOW
      |-> 32'(fast_cnt) == `CCC_FAST_STEP * fast_code - 1;
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("fast decay length");

  property p_fast_entry;
    st.phase == ccc_pkg::PH_ON && pk_s && chm && fast_code != 4'h0 && off_code != 4'h0
      |=> phase_out == ccc_pkg::PH_FAST;
  endproperty
  a_fast_entry: assert property (p_fast_entry) else $error("fast decay not entered");

  property p_valley_end;
    st.phase == ccc_pkg::PH_FAST && !chm && vl_s && off_code != 4'h0
      |=> phase_out == ccc_pkg::PH_SLOW;
  endproperty
  a_valley_end: assert property (p_valley_end) else $error("fast decay not ended");

  // Read data stands one cycle only, so a stale word never reads twice
  property p_rdata_idle;
    !bus_in.rd |=> rdata_out == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

  property p_hyst_dec;
    !reload && st.hdiv != 4'hf |=> st.hyst == $past(st.hyst);
  endproperty
  a_hyst_dec: assert property (p_hyst_dec) else $error("hysteresis stepped early");

  property p_hyst_load;
    reload && !bus_in.wr |=> st.hyst == $past(hstart_v) && st.phase == ccc_pkg::PH_ON;
  endproperty
  a_hyst_load: assert property (p_hyst_load) else $error("hysteresis start");

  property p_cs_off;
    semin == 4'h0 |=> cs_out == $past(run_cur);
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("control not off");

  property p_cs_up;
    acc && semin != 4'h0 && res < lo_thr && st.cs < run_cur && st.cs >= cs_min && !bus_in.wr
      |=> cs_out > $past(cs_out);
  endproperty
  a_cs_up: assert property (p_cs_up) else $error("current not raised");

  property p_cs_dn;
    acc && semin != 4'h0 && res >= hi_thr && st.cool[`CCC_SEDN] == 2'b11
      && st.cs > cs_min && st.cs <= run_cur && !bus_in.wr |=> cs_out == $past(cs_out) - 5'h01;
  endproperty
  a_cs_dn: assert property (p_cs_dn) else $error("current not lowered");

  property p_cs_range;
    semin != 4'h0 && !bus_in.wr |=> cs_out <= $past(run_cur) && cs_out >= $past(cs_min);
  endproperty
  a_cs_range: assert property (p_cs_range) else $error("scale out of range");

  property p_filt;
    st.cool[`CCC_SFILT] && !st.fs_ready |=> $stable(load_result_out);
  endproperty
  a_filt: assert property (p_filt) else $error("filtered update early");

  property p_stall;
    acc |=> stall_out == (load_result_out == 10'h000);
  endproperty
  a_stall: assert property (p_stall) else $error("stall flag wrong");

  c_cycle: cover property (st.phase == ccc_pkg::PH_SLOW ##1 st.phase == ccc_pkg::PH_ON);
  c_fast: cover property (chm && st.phase == ccc_pkg::PH_FAST ##1 st.phase == ccc_pkg::PH_SLOW);
  c_down: cover property (acc && res >= hi_thr ##1 cs_out < $past(cs_out));
  c_filt: cover property (st.cool[`CCC_SFILT] && acc);
  c_stall: cover property ($rose(stall_out));

endmodule : ccc_top
`default_nettype wire

// file: tb/ccc_coil_model.sv
/*
  Comparator model for the chopper pins of ccc_top.
  Assumes phase_in is registered on clk_in; the bench sets the delays.
*/
`timescale 1ns/10ps
`default_nettype none

module ccc_coil_model (
  input wire logic clk_in,
  input wire ccc_pkg::ccc_phase_t phase_in,
  input wire logic [11:0] rise_dly_in,
  input wire logic [11:0] fall_dly_in,
  output logic peak_out,
  output logic valley_out
);
  logic [11:0] cnt = 12'h000;
  ccc_pkg::ccc_phase_t last = ccc_pkg::PH_OFF;
  initial peak_out = 1'b0;
  initial valley_out = 1'b0;

  // Current rises while on, falls in fast decay; pins drop when the phase leaves
  always @(posedge clk_in) begin
    last <= phase_in;
    cnt <= (phase_in != last) ? 12'h000 : cnt + 12'h001;
    peak_out <= (phase_in == ccc_pkg::PH_ON) && (cnt >= rise_dly_in);
    valley_out <= (phase_in == ccc_pkg::PH_FAST) && (cnt >= fall_dly_in);
  end
endmodule : ccc_coil_model
`default_nettype wire

// file: tb/ccc_top_test.sv
/*
  Self-checking bench for ccc_top: registers, chopper phases, smart current.
  Assumes ccc_coil_model answers the comparator pins.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end

module ccc_top_test;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  ccc_pkg::ccc_req_t bus = '0;
  ccc_pkg::ccc_load_t load = '0;
  logic full_step = 1'b0;
  logic [11:0] rise_dly = 12'h0c8;
  logic [11:0] fall_dly = 12'h00a;
  logic peak, valley, drv_en, stall;
  logic [31:0] rdata;
  ccc_pkg::ccc_phase_t phase;
  logic signed [5:0] hyst, sine;
  logic [4:0] cs;
  logic [9:0] result;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  int dn[4] = '{32, 8, 2, 1};

  // 100 MHz system clock
  always #5 sys_clk_in = ~sys_clk_in;

  ccc_top i_ccc_top (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .bus_in(bus),
    .rdata_out(rdata), .peak_reached_in(peak), .valley_reached_in(valley),
    .load_in(load), .full_step_in(full_step), .phase_out(phase),
    .drv_enable_out(drv_en), .hyst_offset_out(hyst), .sine_offset_out(sine),
    .stall_out(stall), .cs_out(cs), .load_result_out(result));

  ccc_coil_model i_ccc_coil_model (.clk_in(sys_clk_in), .phase_in(phase),
    .rise_dly_in(rise_dly), .fall_dly_in(fall_dly), .peak_out(peak),
    .valley_out(valley));

  task automatic test_done();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic to_err();
    num_errors++;
    $display("[ERR] wait exp done got timeout");
    test_done();
  endtask : to_err

  // Bus cycles: one strobe cycle, read data sampled in the cycle after
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge sys_clk_in) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in) bus.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [31:0] ex);
    @(posedge sys_clk_in) bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in) bus.rd <= 1'b0;
    #1;
    `CHK("rdata", ex, rdata)
  endtask : rd_chk

  task automatic ld(input logic [9:0] v);
    @(posedge sys_clk_in) load <= '{valid: 1'b1, value: v};
    @(posedge sys_clk_in) load.valid <= 1'b0;
    #1;
  endtask : ld

  task automatic step();
    @(posedge sys_clk_in) full_step <= 1'b1;
    @(posedge sys_clk_in) full_step <= 1'b0;
  endtask : step

  // Waits until phase equals p (eq=1) or leaves p (eq=0), counting edges
  task automatic wait_ph(input ccc_pkg::ccc_phase_t p, input bit eq, output int k);
    k = 0;
    while ((phase === p) != eq) begin
      @(posedge sys_clk_in) #1;
      k++;
      if (k > 3000) to_err();
    end
  endtask : wait_ph

  task automatic wait_hy(output int k);
    logic signed [5:0] h0;
    h0 = hyst;
    k = 0;
    while (hyst === h0) begin
      @(posedge sys_clk_in) #1;
      k++;
      if (k > 200) to_err();
    end
  endtask : wait_hy

  // Counts high load values until the scale drops once
  task automatic drop_cnt(output int k);
    logic [4:0] c0;
    c0 = cs;
    k = 0;
    while (cs === c0) begin
      ld(10'h080);
      k++;
      if (k > 70) to_err();
    end
  endtask : drop_cnt

  task automatic t_regs();
    rd_chk(7'h10, 32'h0000_1f00);
    rd_chk(7'h6c, 32'h0000_0000);
    rd_chk(7'h6d, 32'h0000_0000);
    rd_chk(7'h6f, 32'h001f_0000);
    `CHK("phase", ccc_pkg::PH_OFF, phase)
    `CHK("drv_en", 1'b0, drv_en)
    wr(7'h6d, 32'hffff_ffff);
    rd_chk(7'h6d, 32'h017f_ef6f);
    wr(7'h6d, 32'h0000_0000);
    rd_chk(7'h33, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_hyst();
    wr(7'h6c, 32'h0000_02b2); // sum 6, off time 2
    wait_ph(ccc_pkg::PH_ON, 1, n);
    `CHK("hyst_start", 6'h06, hyst)
    wait_hy(n);
    wait_hy(n);
    `CHK("hyst_period", 16, n)
    repeat (80) @(posedge sys_clk_in) #1;
    `CHK("hyst_floor", 6'h02, hyst)
    wait_ph(ccc_pkg::PH_FAST, 1, n);
    wait_ph(ccc_pkg::PH_SLOW, 1, n);
    wait_ph(ccc_pkg::PH_ON, 1, n);
    `CHK("slow_len", 88, n)
    $display("test hysteresis done");
  endtask : t_hyst

  task automatic t_const();
    fall_dly <= 12'hfff;
    rise_dly <= 12'h014;
    wr(7'h6c, 32'h0000_4802); // Top bit set, low bits 0: fast time 8
    wait_ph(ccc_pkg::PH_FAST, 1, n);
    wait_ph(ccc_pkg::PH_SLOW, 1, n);
    `CHK("fast_len", 256, n)
    `CHK("hyst_off", 6'h00, hyst)
    `CHK("sine_lo", 6'h3d, sine)
    wr(7'h6c, 32'h0000_4782);
    `CHK("sine_hi", 6'h0c, sine)
    wait_ph(ccc_pkg::PH_ON, 1, n);
    wait_ph(ccc_pkg::PH_ON, 0, n);
    `CHK("no_fast", ccc_pkg::PH_SLOW, phase)
    wr(7'h6c, 32'h0000_0000);
    @(posedge sys_clk_in) #1;
    `CHK("off", ccc_pkg::PH_OFF, phase)
    `CHK("drv_off", 1'b0, drv_en)
    $display("test off time done");
  endtask : t_const

  task automatic t_load();
    wr(7'h10, 32'h0000_1400);
    @(posedge sys_clk_in) #1;
    `CHK("cs_run", 5'h14, cs)
    wr(7'h6d, 32'h0000_2122);
    repeat (7) ld(10'h080);
    `CHK("cs_7", 5'h14, cs)
    ld(10'h080);
    `CHK("cs_8", 5'h13, cs)
    ld(10'h040);
    `CHK("cs_mid", 5'h13, cs)
    ld(10'h03f);
    `CHK("cs_cap", 5'h14, cs)
    wr(7'h6d, 32'h0000_6122);
    ld(10'h07f);
    `CHK("cs_127", 5'h14, cs)
    repeat (13) ld(10'h080);
    `CHK("cs_half", 5'h0a, cs)
    wr(7'h6d, 32'h0000_e122);
    repeat (8) ld(10'h080);
    `CHK("cs_qtr", 5'h05, cs)
    for (int c = 0; c < 4; c++) begin
      wr(7'h6d, 32'h0000_e102 | (32'(c) << 5));
      ld(10'h03f);
      `CHK("cs_up", 5'(5 + (1 << c)), cs)
      repeat (8) ld(10'h080);
    end
    ld(10'h000);
    ld(10'h000);
    for (int c = 0; c < 4; c++) begin
      wr(7'h6d, 32'h0000_8102 | (32'(c) << 13));
      drop_cnt(n);
      drop_cnt(n);
      `CHK("dn_rate", dn[c], n)
    end
    $display("test current done");
  endtask : t_load

  task automatic t_filt();
    wr(7'h6d, 32'h0040_0000);
    ld(10'h064);
    `CHK("res_lo", 10'h000, result)
    `CHK("stall", 1'b1, stall)
    wr(7'h6d, 32'h0001_0000);
    ld(10'h064);
    `CHK("res_hi", 10'h074, result)
    wr(7'h6d, 32'h0100_0000);
    repeat (3) step();
    ld(10'h123);
    `CHK("filt_3", 10'h074, result)
    step();
    ld(10'h123);
    `CHK("filt_4", 10'h123, result)
    ld(10'h155);
    `CHK("filt_shut", 10'h123, result)
    $display("test filter done");
  endtask : t_filt

  // Reset in mid-run while the chopper runs: all state returns to reset values
  task automatic t_rst();
    wr(7'h6c, 32'h0000_0002);
    @(posedge sys_clk_in) srst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    #1;
    `CHK("rst_phase", ccc_pkg::PH_OFF, phase)
    `CHK("rst_cs", 5'h1f, cs)
    rd_chk(7'h6c, 32'h0000_0000);
    rd_chk(7'h10, 32'h0000_1f00);
    $display("test reset done");
  endtask : t_rst

  // Reset for 12 cycles, then the scenarios in order
  initial begin
    repeat (12) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    #1;
    t_regs();
    t_hyst();
    t_const();
    t_load();
    t_filt();
    t_rst();
    test_done();
  end
endmodule : ccc_top_test
`default_nettype wire
